/* low_voltage_stop_release_ctrl.sv */
// Standby entry, wake decision and oscillator stabilization for low-voltage stop.
`timescale 1ns/1ns
// How it works
// - Interrupt controller idles yet detects wake requests.
// - Watchdog 2 runs on osc/8 or used subclock.
// - Watch timer runs only on used subclock.
// - Timer M runs on osc/8 or used subclock.
// - Halt ADC, restart after, mark results invalid.
// - DAC goes high-Z, restores after settling.
// - Realtime output stops, pins hold values.
// - Key input interrupt stays fully running.
// - Port pins keep their entry states.
// - CPU state and RAM are retained.
// - NMI, watchdog, pins, peripherals end standby.
// - Pin, watchdog or detector reset ends standby.
// - Resume only after stabilization wait elapses.
// - Wake happens regardless of request priority.
// - Lower priority in handler: wake, stay pending.
// - Higher or NMI in handler: wake, acknowledge.
// - Masked requests never end standby.
// - NMI release branches to its handler.
// - Maskable: DI continues, EI may branch.
// - Reset release equals an ordinary reset.
// - Regulator level 01H selects low-voltage stop.
// - Dedicated timer counts stabilization down, reaching one resumes.
module low_voltage_stop_release_ctrl #(
  parameter int stab_base_cycles = 8192
) (
  // AHB-Lite slave
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Wake and reset sources
  input  wire lvstop_pkg::wake_req_s wake_req,
  input  wire logic                  reset_pin_request,
  input  wire logic                  watchdog_reset_request,
  input  wire logic                  low_voltage_detector,
  // CPU interrupt context
  input  wire logic                  cpu_int_enabled,
  input  wire logic                  cpu_in_handler,
  input  wire logic [2:0]            cpu_service_prio,
  input  wire logic [2:0]            wake_req_prio,
  // Converter activity
  input  wire logic                  adc_busy,
  input  wire logic                  dac_active,
  // Standby controls
  output lvstop_pkg::unit_ctrl_s     unit_ctrl,
  output logic                       standby_active,
  output logic                       low_voltage_mode,
  output logic                       main_osc_enable,
  output logic                       cpu_clock_enable,
  output logic                       adc_halt,
  output logic                       adc_restart,
  output logic                       adc_result_invalid,
  output logic                       dac_high_z,
  output logic                       dac_restore,
  // Release outcome
  output logic                       resume_pulse,
  output logic                       branch_to_handler,
  output logic                       branch_to_nmi,
  output logic                       wake_ack,
  output logic                       wake_pending,
  output logic                       system_reset_request
);
  import lvstop_pkg::*;

  // ==========================================================================
  // Bus front end
  // ==========================================================================
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        addr_phase;
  logic [31:0] read_value;

  logic [7:0]  ctrl_reg;
  logic [7:0]  regovl_reg;
  logic [2:0]  stabilization_time_select_reg;
  logic [4:0]  clksel_reg;
  logic [11:0] intmask_reg;
  logic        adc_invalid_reg;
  pm_state_e   state_reg;
  wake_kind_e  wake_kind_reg;
  logic [stab_width-1:0] stab_cnt_reg;
  logic        adc_was_busy_reg;
  logic        dac_was_active_reg;
  logic [15:0] dac_cnt_reg;
  logic        enter_req;
  logic        any_reset;
  logic        nmi_wake;
  logic        maskable_wake;
  logic        subclk_used;

  assign addr_phase = hsel && htrans[1] && hready;
  assign any_reset  = reset_pin_request || watchdog_reset_request || low_voltage_detector;
  assign subclk_used = ctrl_reg[ctrl_subclk_bit];
  assign enter_req  = wr_pend_reg && (wr_addr_reg == ctrl_addr) && hwdata[ctrl_enter_bit];

  always_comb begin
    read_value = 32'h0000_0000;
    case (haddr[7:0])
      ctrl_addr:    read_value[7:0] = ctrl_reg;
      regovl_addr:  read_value[7:0] = regovl_reg;
      stabilization_time_select_addr:    read_value[2:0] = stabilization_time_select_reg;
      clksel_addr:  read_value[4:0] = clksel_reg;
      intmask_addr: read_value[11:0] = intmask_reg;
      status_addr:  read_value[7:0] = {2'h0, adc_invalid_reg, wake_kind_reg,
                                       low_voltage_mode, state_reg};
      default:      read_value = 32'h0000_0000;
    endcase
  end

  // Read data is fetched in the address phase so the slave never inserts wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= read_value;
        end
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg    <= 8'h00;
      regovl_reg  <= regovl_reset;
      stabilization_time_select_reg    <= stabilization_time_select_reset;
      clksel_reg  <= 5'h00;
      intmask_reg <= 12'h000;
    end else if (any_reset) begin
      ctrl_reg    <= 8'h00;
      regovl_reg  <= regovl_reset;
      stabilization_time_select_reg    <= stabilization_time_select_reset;
      clksel_reg  <= 5'h00;
      intmask_reg <= 12'h000;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        ctrl_addr: begin
          ctrl_reg <= {3'h0, hwdata[4:1], 1'b0};
        end
        regovl_addr:  regovl_reg  <= hwdata[7:0];
        stabilization_time_select_addr:    stabilization_time_select_reg    <= hwdata[2:0];
        clksel_addr:  clksel_reg  <= hwdata[4:0];
        intmask_addr: intmask_reg <= hwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Wake qualification
  // ==========================================================================
  // mask bits
  always_comb begin
    nmi_wake = (wake_req.nmi_pin && !ctrl_reg[ctrl_nmi_pin_bit]) ||
               (wake_req.watchdog_nmi_request && !ctrl_reg[ctrl_wdt_nmi_bit]);
    maskable_wake = !ctrl_reg[ctrl_maskable_bit] &&
                    (|({wake_req.peripheral_requests, wake_req.external_pin_requests} &
                       ~intmask_reg));
  end

  // ==========================================================================
  // Standby sequencer
  // ==========================================================================
  // dedicated stabilization timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= st_run;
      wake_kind_reg <= wake_none;
      stab_cnt_reg  <= '0;
    end else if (any_reset) begin
      state_reg     <= st_run;
      wake_kind_reg <= wake_none;
      stab_cnt_reg  <= '0;
    end else begin
      case (state_reg)
        st_run: begin
          if (enter_req) begin
            state_reg <= st_stop;
          end
        end
        st_stop: begin
          if (nmi_wake || maskable_wake) begin
            state_reg     <= st_stable;
            wake_kind_reg <= nmi_wake ? wake_nmi : wake_maskable;
            stab_cnt_reg  <= stab_width'(stab_base_cycles) << stabilization_time_select_reg;
          end
        end
        st_stable: begin
          if (stab_cnt_reg <= stab_width'(1)) begin
            state_reg <= st_run;
          end else begin
            stab_cnt_reg <= stab_cnt_reg - stab_width'(1);
          end
        end
        default: state_reg <= st_run;
      endcase
    end
  end

  // ==========================================================================
  // Release outcome
  // ==========================================================================
  logic stab_done;
  logic higher_prio;
  assign stab_done   = (state_reg == st_stable) && (stab_cnt_reg <= stab_width'(1));
  assign higher_prio = !cpu_in_handler || (wake_req_prio < cpu_service_prio);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume_pulse      <= 1'b0;
      branch_to_handler <= 1'b0;
      branch_to_nmi     <= 1'b0;
      wake_ack          <= 1'b0;
      wake_pending      <= 1'b0;
    end else begin
      resume_pulse      <= stab_done && !any_reset;
      branch_to_handler <= 1'b0;
      branch_to_nmi     <= 1'b0;
      wake_ack          <= 1'b0;
      if (stab_done && !any_reset) begin
        if (wake_kind_reg == wake_nmi) begin
          branch_to_nmi <= 1'b1;
          wake_ack      <= 1'b1;
          wake_pending  <= 1'b0;
        end else if (cpu_int_enabled && higher_prio) begin
          branch_to_handler <= 1'b1;
          wake_ack          <= 1'b1;
          wake_pending      <= 1'b0;
        end else begin
          wake_pending <= 1'b1;
        end
      end else if (any_reset || (state_reg == st_run && enter_req)) begin
        wake_pending <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Unit controls during standby
  // ==========================================================================
  logic in_standby;
  logic lv_sel;
  logic any_reset_prev_reg;
  assign in_standby = (state_reg != st_run);
  assign lv_sel = (regovl_reg == regovl_low_voltage);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_ctrl        <= '{default: 1'b0};
      standby_active   <= 1'b0;
      low_voltage_mode <= 1'b0;
      main_osc_enable  <= 1'b1;
      cpu_clock_enable <= 1'b1;
      system_reset_request <= 1'b0;
      any_reset_prev_reg   <= 1'b0;
    end else begin
      standby_active   <= in_standby;
      low_voltage_mode <= (state_reg == st_stop) && lv_sel;
      main_osc_enable  <= state_reg != st_stop;
      cpu_clock_enable <= !in_standby;
      any_reset_prev_reg   <= any_reset;
      system_reset_request <= any_reset && !any_reset_prev_reg;
      unit_ctrl.intc_detect_only <= in_standby;
      unit_ctrl.wdt2_run <= !in_standby ||
        (clksel_reg[clksel_wdt_lsb +: 2] == clk_osc_div8) ||
        (clksel_reg[clksel_wdt_lsb +: 2] == clk_subclock && subclk_used);
      unit_ctrl.watch_timer_run <= !in_standby ||
        (subclk_used && clksel_reg[clksel_watch_bit]);
      unit_ctrl.interval_timer_m_run <= !in_standby ||
        (clksel_reg[clksel_tmm_lsb +: 2] == clk_osc_div8) ||
        (clksel_reg[clksel_tmm_lsb +: 2] == clk_subclock && subclk_used);
      unit_ctrl.realtime_output_hold <= in_standby;
      unit_ctrl.key_input_interrupt_run <= 1'b1;
      unit_ctrl.port_hold <= in_standby;
      unit_ctrl.state_retain <= in_standby;
    end
  end

  // ==========================================================================
  // Converters
  // ==========================================================================
  // ADC halt and restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_halt         <= 1'b0;
      adc_restart      <= 1'b0;
      adc_was_busy_reg <= 1'b0;
      adc_invalid_reg  <= 1'b0;
    end else if (any_reset) begin
      adc_halt         <= 1'b0;
      adc_restart      <= 1'b0;
      adc_was_busy_reg <= 1'b0;
      adc_invalid_reg  <= 1'b0;
    end else begin
      adc_restart <= 1'b0;
      if (state_reg == st_run && enter_req) begin
        adc_was_busy_reg <= adc_busy;
      end
      adc_halt <= in_standby && adc_was_busy_reg;
      if (stab_done && adc_was_busy_reg) begin
        adc_restart      <= 1'b1;
        adc_was_busy_reg <= 1'b0;
      end
      // Setting wins over the software clear in the same cycle.
      if (state_reg == st_run && enter_req && adc_busy) begin
        adc_invalid_reg <= 1'b1;
      end else if (wr_pend_reg && wr_addr_reg == ctrl_addr && hwdata[ctrl_adc_clr_bit]) begin
        adc_invalid_reg <= 1'b0;
      end
    end
  end
  assign adc_result_invalid = adc_invalid_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_high_z         <= 1'b0;
      dac_restore        <= 1'b0;
      dac_was_active_reg <= 1'b0;
      dac_cnt_reg        <= 16'h0000;
    end else if (any_reset) begin
      dac_high_z         <= 1'b0;
      dac_restore        <= 1'b0;
      dac_was_active_reg <= 1'b0;
      dac_cnt_reg        <= 16'h0000;
    end else begin
      dac_restore <= 1'b0;
      if (state_reg == st_run && enter_req) begin
        dac_was_active_reg <= dac_active;
      end
      if (in_standby && dac_was_active_reg) begin
        dac_high_z <= 1'b1;
      end
      if (stab_done && dac_was_active_reg) begin
        dac_cnt_reg <= 16'(dac_settle_cycles);
      end else if (dac_cnt_reg != 16'h0000) begin
        dac_cnt_reg <= dac_cnt_reg - 16'h0001;
        if (dac_cnt_reg == 16'h0001) begin
          dac_high_z         <= 1'b0;
          dac_restore        <= 1'b1;
          dac_was_active_reg <= 1'b0;
        end
      end
    end
  end

endmodule

/* lvstop_pkg.sv */
// Shared constants, register map and carrier types of the low-voltage stop controller.
package lvstop_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ctrl_addr    = 8'h00;
  localparam logic [7:0] regovl_addr  = 8'h04;
  localparam logic [7:0] stabilization_time_select_addr    = 8'h08;
  localparam logic [7:0] clksel_addr  = 8'h0c;
  localparam logic [7:0] intmask_addr = 8'h10;
  localparam logic [7:0] status_addr  = 8'h14;

  // Control register fields.
  localparam int ctrl_enter_bit    = 0;
  localparam int ctrl_subclk_bit   = 1;
  localparam int ctrl_nmi_pin_bit  = 2;
  localparam int ctrl_wdt_nmi_bit  = 3;
  localparam int ctrl_maskable_bit = 4;
  localparam int ctrl_adc_clr_bit  = 5;

  // Clock select fields: two bits each for the watchdog and timer M, one for the watch timer.
  localparam int clksel_wdt_lsb   = 0;
  localparam int clksel_tmm_lsb   = 2;
  localparam int clksel_watch_bit = 4;
  localparam logic [1:0] clk_osc_div8 = 2'h0;
  localparam logic [1:0] clk_subclock = 2'h1;

  // Regulator level value that turns plain stop into low-voltage stop.
  localparam logic [7:0] regovl_low_voltage = 8'h01;
  localparam logic [7:0] regovl_reset       = 8'h00;
  localparam logic [2:0] stabilization_time_select_reset         = 3'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int clk_mhz          = 50;
  localparam int dac_settle_ns    = 2000;
  localparam int dac_settle_cycles = (dac_settle_ns * clk_mhz + 999) / 1000;
  localparam int stab_width       = 24;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    st_run    = 2'b00,
    st_stop   = 2'b01,
    st_stable = 2'b10
  } pm_state_e;

  typedef enum logic [1:0] {
    wake_none      = 2'b00,
    wake_nmi       = 2'b01,
    wake_maskable  = 2'b10
  } wake_kind_e;

  // Wake request inputs.
  typedef struct packed {
    logic       nmi_pin;
    logic       watchdog_nmi_request;
    logic [7:0] external_pin_requests;
    logic [3:0] peripheral_requests;
  } wake_req_s;

  // Per-unit run and hold controls driven during standby.
  typedef struct packed {
    logic intc_detect_only;
    logic wdt2_run;
    logic watch_timer_run;
    logic interval_timer_m_run;
    logic realtime_output_hold;
    logic key_input_interrupt_run;
    logic port_hold;
    logic state_retain;
  } unit_ctrl_s;

endpackage

/* lvstop_chk.sv */
// Concurrent checks on the ports of the low-voltage stop controller.
`timescale 1ns/1ns
module lvstop_chk (
  // Clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // Watched ports
  input wire logic                   standby_active,
  input wire logic                   main_osc_enable,
  input wire lvstop_pkg::unit_ctrl_s unit_ctrl,
  input wire logic                   resume_pulse,
  input wire logic                   branch_to_nmi,
  input wire logic                   branch_to_handler,
  input wire logic                   wake_ack,
  input wire logic                   wake_pending,
  input wire logic                   dac_restore,
  input wire logic                   system_reset_request,
  input wire logic                   reset_pin_request,
  input wire logic                   watchdog_reset_request,
  input wire logic                   low_voltage_detector
);
  import lvstop_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // Entry
  // ==========================================================================
  a_osc_stopped: assert property ($rose(standby_active) |-> !main_osc_enable)
    else $error("main oscillator running at standby entry");
  a_port_retain: assert property (
    $rose(standby_active) |-> unit_ctrl.port_hold && unit_ctrl.state_retain)
    else $error("ports or state not held at standby entry");
  a_intc_detect: assert property (
    $rose(standby_active) |-> unit_ctrl.intc_detect_only && unit_ctrl.realtime_output_hold)
    else $error("interrupt detect or output hold missing in standby");
  a_key_running: assert property ($past(hresetn) |-> unit_ctrl.key_input_interrupt_run)
    else $error("key input unit stopped");
  // ==========================================================================
  // Release
  // ==========================================================================
  a_nmi_outcome: assert property (
    branch_to_nmi |-> resume_pulse && wake_ack && !branch_to_handler)
    else $error("nmi branch without resume and acknowledge");
  a_handler_ack: assert property (branch_to_handler |-> resume_pulse && wake_ack)
    else $error("handler branch without resume and acknowledge");
  a_pending_noack: assert property ($rose(wake_pending) |-> resume_pulse && !wake_ack)
    else $error("pending request was acknowledged");
  a_resume_single: assert property (resume_pulse |=> (!resume_pulse) [*4])
    else $error("resume repeated without a new standby");
  a_reset_clears: assert property (
    (reset_pin_request || watchdog_reset_request || low_voltage_detector) |->
    ##2 !standby_active && !resume_pulse)
    else $error("reset source did not end standby");
  a_reset_pulse: assert property (system_reset_request |=> !system_reset_request)
    else $error("reset request longer than one cycle");
  a_dac_after: assert property (dac_restore |-> !standby_active)
    else $error("converter restored inside standby");
  c_nmi: cover property (branch_to_nmi);
  c_pending: cover property ($rose(wake_pending));
  c_reset: cover property (system_reset_request && $past(standby_active));
  c_dac: cover property (dac_restore);
endmodule

/* lvstop_partner.sv */
// Model of the wake sources, reset sources and external clock partner.
`timescale 1ns/1ns
module lvstop_partner (
  // Clock and command from the bench
  input wire logic              hclk,
  input wire logic              standby_active,
  input wire logic              go,
  input wire logic [4:0]        src,
  // Source lines
  output lvstop_pkg::wake_req_s wake_req,
  output logic                  reset_pin_request,
  output logic                  watchdog_reset_request,
  output logic                  low_voltage_detector,
  output logic                  ext_serial_clk
);
  import lvstop_pkg::*;
  logic [16:0] lines = '0;
  logic        clk_q = 1'b0;
  // One source line at a time, a registered level as real sources give.
  always @(posedge hclk) begin
    lines <= go ? (17'h1 << src) : 17'h0;
  end
  always @(posedge hclk) begin
    clk_q <= standby_active ? 1'b0 : ~clk_q;
  end
  assign ext_serial_clk = clk_q;
  assign wake_req = {lines[0], lines[1], lines[9:2], lines[13:10]};
  assign reset_pin_request = lines[14];
  assign watchdog_reset_request = lines[15];
  assign low_voltage_detector = lines[16];
endmodule

/* low_voltage_stop_release_ctrl_tb.sv */
// Self-checking bench for the low-voltage stop controller.
`timescale 1ns/1ns
module low_voltage_stop_release_ctrl_tb;
  import lvstop_pkg::*;
  localparam int stab = 4;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cpu_service_prio, wake_req_prio, evs;
  wake_req_s   wake_req;
  unit_ctrl_s  unit_ctrl;
  logic        reset_pin_request, watchdog_reset_request, low_voltage_detector;
  logic        cpu_int_enabled, cpu_in_handler, adc_busy, dac_active, go;
  logic        standby_active, low_voltage_mode, main_osc_enable, cpu_clock_enable;
  logic        adc_halt, adc_restart, adc_result_invalid, dac_high_z, dac_restore;
  logic        resume_pulse, branch_to_handler, branch_to_nmi, wake_ack, wake_pending;
  logic        system_reset_request, ext_serial_clk, nmi, br, wdt, tmm, wch;
  logic [4:0]  src, s;
  logic [5:0]  ei_t = 6'b111001;
  logic [5:0]  inh_t = 6'b110001;
  logic [5:0]  hi_t = 6'b100000;
  int          err_total, compares, seed, n, lo;
  int          mdl[8];
  int          base_t[6] = '{0, 1, 2, 2, 10, 10};
  assign hready = hreadyout;
  assign evs = {dac_restore, system_reset_request, resume_pulse};
  low_voltage_stop_release_ctrl #(.stab_base_cycles(stab)) i_low_voltage_stop_release_ctrl (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .wake_req, .reset_pin_request, .watchdog_reset_request,
    .low_voltage_detector, .cpu_int_enabled, .cpu_in_handler, .cpu_service_prio,
    .wake_req_prio, .adc_busy, .dac_active, .unit_ctrl, .standby_active, .low_voltage_mode,
    .main_osc_enable, .cpu_clock_enable, .adc_halt, .adc_restart, .adc_result_invalid,
    .dac_high_z, .dac_restore, .resume_pulse, .branch_to_handler, .branch_to_nmi, .wake_ack,
    .wake_pending, .system_reset_request);
  lvstop_partner i_lvstop_partner (.hclk, .standby_active, .go, .src, .wake_req,
    .reset_pin_request, .watchdog_reset_request, .low_voltage_detector, .ext_serial_clk);
  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic finish_test();
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait on one of the event lines, seen at falling edges.
  task automatic wait_for(input int k, input int lim);
    n = 0;
    while (evs[k] !== 1'b1 && n < lim) begin
      @(negedge hclk);
      n++;
    end
    if (evs[k] !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic rdy();
    int c = 0;
    do begin
      @(posedge hclk);
      c++;
    end while (hready !== 1'b1 && c < 50);
    if (hready !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  function automatic logic [31:0] rmask(input int i);
    case (i)
      0: return 32'h1e;
      1: return 32'hff;
      2: return 32'h7;
      3: return 32'h1f;
      4: return 32'hfff;
      default: return 32'h0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a < status_addr) mdl[a[4:2]] = d;
  endtask
  task automatic rdm(input logic [7:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, mdl[a[4:2]] & rmask(int'(a[4:2])));
  endtask
  // Standby_active rises one edge after the entering write lands.
  task automatic enter(input logic [31:0] d);
    wr(ctrl_addr, d);
    repeat (2) @(negedge hclk);
  endtask
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    seed = 32'h5cec7491;
    err_total = 0;
    compares = 0;
    hresetn = 1'b0;
    {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    {go, src, cpu_int_enabled, cpu_in_handler, adc_busy, dac_active} = '0;
    {cpu_service_prio, wake_req_prio} = '0;
    mdl = '{default: 0};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    wr(status_addr, 32'hffffffff);
    wr(8'h18, 32'h5a5a5a5a);
    for (int a = 0; a < 7; a++) rdm(8'(a * 4));
    chk(hresp, 1'b0);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      s = base_t[i] == 2 ? 5'(2 + r[9:7]) :
          (base_t[i] == 10 ? 5'(10 + r[11:10]) : 5'(base_t[i]));
      wr(regovl_addr, {31'h0, r[0]});
      wr(stabilization_time_select_addr, 32'(i % 2));
      wr(clksel_addr, {27'h0, r[4], 1'b0, r[3], 1'b0, r[2]});
      rdm(clksel_addr);
      @(posedge hclk);
      cpu_int_enabled <= ei_t[i];
      cpu_in_handler <= inh_t[i];
      cpu_service_prio <= 3'h3;
      wake_req_prio <= hi_t[i] ? 3'h1 : 3'h5;
      adc_busy <= r[5];
      dac_active <= r[6];
      enter({30'h0, r[1], 1'b1});
      wdt = !r[2] | r[1];
      tmm = !r[3] | r[1];
      wch = r[4] & r[1];
      chk({standby_active, main_osc_enable, cpu_clock_enable}, 3'h4);
      chk(unit_ctrl, {1'b1, wdt, wch, tmm, 4'hf});
      chk({low_voltage_mode, adc_halt, dac_high_z}, {r[0], r[5], r[6]});
      @(posedge hclk);
      go <= 1'b1;
      src <= s;
      wait_for(0, 300);
      lo = stab << (i % 2);
      chk(n >= lo && n <= lo + 5, 1'b1);
      nmi = s < 2;
      br = !nmi & ei_t[i] & (!inh_t[i] | hi_t[i]);
      chk({branch_to_nmi, branch_to_handler, wake_ack, wake_pending & ei_t[i], adc_restart},
          {nmi, br, nmi | br, !nmi & ei_t[i] & !br, r[5]});
      @(negedge hclk);
      chk({cpu_clock_enable, standby_active}, 2'h2);
      if (r[6]) wait_for(2, 150);
      if (r[6]) chk(n >= 85 && n <= 110, 1'b1);
      chk(adc_result_invalid, r[5]);
      @(posedge hclk);
      go <= 1'b0;
      wr(ctrl_addr, 32'h20);
      @(negedge hclk);
      chk(adc_result_invalid, 1'b0);
    end
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      wr(intmask_addr, 32'hfff);
      enter(32'h1d);
      @(posedge hclk);
      go <= 1'b1;
      src <= k == 2 ? 5'(2 + r[2:0]) : 5'(k);
      repeat (3 * stab + 4) @(negedge hclk);
      chk(standby_active, 1'b1);
      @(posedge hclk);
      src <= 5'(14 + k);
      wait_for(1, 10);
      @(negedge hclk);
      chk({standby_active, main_osc_enable, dac_high_z, adc_result_invalid}, 4'h4);
      @(posedge hclk);
      go <= 1'b0;
      mdl = '{default: 0};
      rdm(intmask_addr);
    end
    finish_test();
  end
endmodule
bind low_voltage_stop_release_ctrl lvstop_chk i_lvstop_chk (
  .hclk, .hresetn, .standby_active, .main_osc_enable, .unit_ctrl, .resume_pulse,
  .branch_to_nmi, .branch_to_handler, .wake_ack, .wake_pending, .dac_restore,
  .system_reset_request, .reset_pin_request, .watchdog_reset_request, .low_voltage_detector);
